/* logic/ecr_defines.svh */
`ifndef ECR_DEFINES_SVH
`define ECR_DEFINES_SVH

// Register offsets on the host port
`define ECR_VIOL_HI 8'h00
`define ECR_VIOL_LO 8'h01
`define ECR_BLK_HI 8'h02
`define ECR_BLK_LO 8'h03
`define ECR_FAR_HI 8'h04
`define ECR_FAR_LO 8'h05
`define ECR_ALIGN_HI 8'h06
`define ECR_ALIGN_LO 8'h07

// Counter width and saturation value
`define ECR_CNT_W 16
`define ECR_CNT_MAX 16'hffff
`define ECR_CNT_RESET 16'h0000

// Data returned for offsets outside the block
`define ECR_UNMAPPED 8'h00

`endif

/* logic/ecr_pkg.sv */
`include "ecr_defines.svh"

package ecr_pkg;

	typedef logic [`ECR_CNT_W-1:0] ecr_count_t;

	// Error events from the framer, line decoder and pattern checker
	typedef struct packed {
		logic bipolar_violation;
		logic hdb3_codeword;
		logic code_violation;
		logic crc_block_error;
		logic e_bit_valid;
		logic e_bit_value;
		logic pattern_bit_error;
		logic align_word_error;
	} ecr_events_t;

	// Synchronisation state from the framer and pattern checker
	typedef struct packed {
		logic receive_sync_lost;
		logic frame_align_lost;
		logic crc_mf_lost;
		logic frame_search;
		logic sig_mf_search;
		logic crc_mf_search;
		logic pattern_sync;
	} ecr_sync_t;

	// Configuration bits
	typedef struct packed {
		logic violation_type_select;
		logic receive_line_code_select;
		logic pattern_check_enable;
		logic fast_interval_select;
	} ecr_cfg_t;

	typedef enum logic [1:0] {
		ECR_SRC_VIOL,
		ECR_SRC_BLK,
		ECR_SRC_FAR,
		ECR_SRC_ALIGN
	} ecr_src_t;

endpackage

/* logic/ecr_counters.sv */
// Notes on behaviour
// - All four counters update at each interval tick, one second or 62.5ms.
// - Readable registers show the previous complete interval, not live counts.
// - Every counter stops at its maximum and never wraps.
// - With pattern checking on, far-end counter counts pattern bit errors.
// - Violation count is 16 bits, high byte at 00, low byte at 01.
// - Violation type 0 counts bipolar violations: same-polarity marks.
// - In bipolar mode with HDB3 decoding, substitution codewords are ignored.
// - Violation type 1 counts code violations.
// - Violation counter counts always, regardless of sync loss.
// - Violation counter holds at 65,535 without rolling over.
// - Block-check error counter, 16 bits at 02 and 03, per errored codeword.
// - Block counter, and far-end counter outside pattern mode, stop on frame or CRC4 sync loss.
// - Far-end counter at 04 and 05 counts each received E bit of 0.
// - In pattern mode, far-end counter counts only while pattern-synced.
// - Alignment-word error counter, 16 bits at 06 and 07.
// - Alignment counter stops on sync lost or any alignment search.
// - Interval flag comes from the line-clock tick, per selected interval; here it registers interval_tick and ignores fast_interval_select.
// - Sync-lost flag is high whenever framer lacks synchronisation.
`timescale 1ns/1ps
`default_nettype none
`include "ecr_defines.svh"

module ecr_counters (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic interval_tick,
	input wire ecr_pkg::ecr_cfg_t cfg,
	input wire ecr_pkg::ecr_events_t events,
	input wire ecr_pkg::ecr_sync_t sync,
	input wire logic [7:0] reg_addr,
	output logic [7:0] reg_rdata,
	output logic interval_tick_flag,
	output logic receive_sync_lost
);
	import ecr_pkg::*;

	// Saturating increment shared by all four accumulators
	function automatic ecr_count_t sat_inc(input ecr_count_t v,
		input logic inc);
		ecr_count_t r;
		r = v;
		if (inc && v != `ECR_CNT_MAX) begin
			r = v + 16'h0001;
		end
		return r;
	endfunction

	// Reset release through two flops; async assert
	logic rst_meta;
	logic rst_sync_n;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	logic inc_viol;
	logic inc_blk;
	logic inc_far;
	logic inc_align;
	logic framed_ok;

	// Event qualification
	always_comb begin
		framed_ok = !sync.frame_align_lost && !sync.crc_mf_lost;
		if (cfg.violation_type_select) begin
			inc_viol = events.code_violation;
		end else begin
			inc_viol = events.bipolar_violation;
			if (cfg.receive_line_code_select && events.hdb3_codeword) begin
				inc_viol = 1'b0;
			end
		end
		inc_blk = events.crc_block_error && framed_ok;
		if (cfg.pattern_check_enable) begin
			inc_far = events.pattern_bit_error && sync.pattern_sync;
		end else begin
			inc_far = events.e_bit_valid && !events.e_bit_value &&
				framed_ok;
		end
		// gated by sync lost and searches
		inc_align = events.align_word_error && !sync.receive_sync_lost &&
			!sync.frame_search && !sync.sig_mf_search &&
			!sync.crc_mf_search;
	end

	ecr_count_t acc [4];
	ecr_count_t held [4];
	ecr_count_t next_acc [4];
	ecr_count_t next_held [4];
	logic next_tick_flag;
	logic next_sync_lost;

	// Accumulate; on tick copy out and restart
	always_comb begin
		logic [3:0] inc;
		inc = {inc_align, inc_far, inc_blk, inc_viol};
		for (int i = 0; i < 4; i++) begin
			next_held[i] = held[i];
			if (interval_tick) begin
				next_held[i] = acc[i];
				// An event on the tick opens the new interval
				next_acc[i] = inc[i] ? 16'h0001 : `ECR_CNT_RESET;
			end else begin
				next_acc[i] = sat_inc(acc[i], inc[i]);
			end
		end
		next_tick_flag = interval_tick;
		next_sync_lost = sync.receive_sync_lost;
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			for (int i = 0; i < 4; i++) begin
				acc[i] <= `ECR_CNT_RESET;
				held[i] <= `ECR_CNT_RESET;
			end
			interval_tick_flag <= 1'b0;
			receive_sync_lost <= 1'b0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				acc[i] <= next_acc[i];
				held[i] <= next_held[i];
			end
			interval_tick_flag <= next_tick_flag;
			receive_sync_lost <= next_sync_lost;
		end
	end

	logic [7:0] next_rdata;

	// Read decode; registered so data comes from flops
	always_comb begin
		unique case (reg_addr)
			`ECR_VIOL_HI: next_rdata = held[ECR_SRC_VIOL][15:8];
			`ECR_VIOL_LO: next_rdata = held[ECR_SRC_VIOL][7:0];
			`ECR_BLK_HI: next_rdata = held[ECR_SRC_BLK][15:8];
			`ECR_BLK_LO: next_rdata = held[ECR_SRC_BLK][7:0];
			`ECR_FAR_HI: next_rdata = held[ECR_SRC_FAR][15:8];
			`ECR_FAR_LO: next_rdata = held[ECR_SRC_FAR][7:0];
			`ECR_ALIGN_HI: next_rdata = held[ECR_SRC_ALIGN][15:8];
			`ECR_ALIGN_LO: next_rdata = held[ECR_SRC_ALIGN][7:0];
			default: next_rdata = `ECR_UNMAPPED;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule
`default_nettype wire

/* verification/ecr_counters_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ecr_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic interval_tick,
	input wire ecr_pkg::ecr_cfg_t cfg,
	input wire ecr_pkg::ecr_events_t events,
	input wire ecr_pkg::ecr_sync_t sync,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic interval_tick_flag,
	input wire logic receive_sync_lost
);
	logic [15:0] va, vh;
	logic inc;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Shadow violation count, never gated
	assign inc = cfg.violation_type_select ? events.code_violation :
		events.bipolar_violation &&
		!(cfg.receive_line_code_select && events.hdb3_codeword);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			{va, vh} <= '0;
		else if (interval_tick)
			{va, vh} <= {15'h0, inc, va};
		else if (!(&va))
			va <= va + 16'(inc);
	end
	a_tick_flag: assert property (interval_tick |=>
		interval_tick_flag) else $error("flag missing");
	a_no_flag: assert property (!interval_tick |=>
		!interval_tick_flag) else $error("stray flag");
	a_sync_hi: assert property (sync.receive_sync_lost |=>
		receive_sync_lost) else $error("sync lost not shown");
	a_sync_lo: assert property (!sync.receive_sync_lost |=>
		!receive_sync_lost) else $error("sync lost stuck");
	a_unmapped_zero: assert property (|reg_addr[7:3] |=>
		!reg_rdata) else $error("unmapped not zero");
	a_read_stable: assert property (!interval_tick ##1
		(!interval_tick && $stable(reg_addr)) |=> $stable(reg_rdata))
		else $error("held value moved");
	a_viol_high: assert property (reg_addr == 8'h00 |=>
		reg_rdata == $past(vh[15:8])) else $error("viol high wrong");
	a_viol_low: assert property (reg_addr == 8'h01 |=>
		reg_rdata == $past(vh[7:0])) else $error("viol low wrong");
endmodule
bind ecr_counters ecr_chk i_chk (.mclk, .rst_n, .interval_tick, .cfg,
	.events, .sync, .reg_addr, .reg_rdata, .interval_tick_flag,
	.receive_sync_lost);
`default_nettype wire

/* verification/ecr_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ecr_line_model (
	input wire logic mclk,
	input wire logic run,
	input wire logic storm,
	output ecr_pkg::ecr_events_t events,
	output ecr_pkg::ecr_sync_t sync
);
	initial {events, sync} = '0;
	// Framer outputs move just after each edge; storm fires every event
	always @(posedge mclk) begin
		#1;
		events <= !run ? '0 : storm ? '1 : 8'($urandom);
		sync <= !run ? '0 : storm ? 7'h01 : 7'($urandom & $urandom);
	end
endmodule
`default_nettype wire

/* verification/e1_error_count_registers_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module e1_error_count_registers_bench;
	import ecr_pkg::*;
	logic mclk, rst_n, interval_tick, run, storm, flag, lost, lf;
	ecr_cfg_t cfg;
	ecr_events_t ev;
	ecr_sync_t sy;
	logic [7:0] reg_addr, reg_rdata;
	int n_errors, total_checks, acc[4], held[4], q[4], e_rd, e_fl, e_sl;
	ecr_counters i_dut (.mclk, .rst_n, .interval_tick, .cfg, .events(ev),
		.sync(sy), .reg_addr, .reg_rdata, .interval_tick_flag(flag),
		.receive_sync_lost(lost));
	ecr_line_model i_far (.mclk, .run, .storm, .events(ev), .sync(sy));
	initial begin
		mclk = 0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(string n, int e, logic [7:0] s);
		total_checks++;
		if (s !== e[7:0]) begin
			n_errors++;
			$display("BAD %s exp %0h got %0h", n, e[7:0], s);
		end
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Reference: gated counts, copy-and-clear at tick, saturate
	always @(posedge mclk) if (rst_n) begin
		e_rd = reg_addr < 8 ? held[reg_addr[2:1]] >> (reg_addr[0] ? 0 : 8) : 0;
		e_fl = interval_tick;
		e_sl = sy.receive_sync_lost;
		lf = sy.frame_align_lost | sy.crc_mf_lost;
		q[0] = cfg.violation_type_select ? ev.code_violation :
			ev.bipolar_violation & ~(cfg.receive_line_code_select & ev.hdb3_codeword);
		q[1] = ev.crc_block_error & ~lf;
		q[2] = cfg.pattern_check_enable ? ev.pattern_bit_error & sy.pattern_sync
			: ev.e_bit_valid & ~ev.e_bit_value & ~lf;
		q[3] = ev.align_word_error & ~(sy.receive_sync_lost | sy.frame_search |
			sy.sig_mf_search | sy.crc_mf_search);
		for (int i = 0; i < 4; i++)
			if (interval_tick) {held[i], acc[i]} = {acc[i], q[i]};
			else if (acc[i] < 65535) acc[i] += q[i];
	end
	// Outputs settle by the falling edge
	always @(negedge mclk) if (run) begin
		chk("rdata", e_rd, reg_rdata);
		chk("flag", e_fl, flag);
		chk("lost", e_sl, lost);
	end
	initial begin
		#450000;
		n_errors++;
		conclude;
	end
	initial begin
		void'($urandom(21844));
		{rst_n, interval_tick, run, storm, cfg, reg_addr} = '0;
		repeat (12) @(posedge mclk);
		#1 rst_n = 1;
		repeat (3) @(posedge mclk);
		#1 run = 1;
		// random config per interval, a random offset 0 to 11 read each cycle
		repeat (40) begin
			for (int j = 0; j < 150; j++) begin
				@(posedge mclk);
				#1 reg_addr = 8'($urandom % 12);
				interval_tick = (j == 149);
				// any line code choice is legal
				if (j == 0) cfg = 4'($urandom);
			end
		end
		$display("random intervals done");
		// all four counters run into saturation
		cfg = 4'h2;
		storm = 1;
		@(posedge mclk);
		#1 interval_tick = 0;
		repeat (66000) @(posedge mclk);
		#1 interval_tick = 1;
		for (int a = 0; a < 9; a++) begin
			@(posedge mclk);
			#1 interval_tick = 0;
			reg_addr = 8'(a);
		end
		@(posedge mclk);
		$display("saturation done");
		conclude;
	end
endmodule
`default_nettype wire
